// ==== rtl/arb_if.sv ====
`timescale 1ns/100ps
interface arb_if;
  logic [reset_seq_pkg::IRQ_N-1:0] pend; // bit 0 is priority 1
  logic any;
  logic [$clog2(reset_seq_pkg::IRQ_N)-1:0] idx;
  modport arb (input pend, output any, output idx);
  modport user (output pend, input any, input idx);
endinterface

// ==== rtl/irq_priority.sv ====
`timescale 1ns/100ps
module irq_priority (
  arb_if.arb bus // pending set in, winner out
);
  localparam int N = reset_seq_pkg::IRQ_N;
  localparam int W = $clog2(N);

  generate
    if (N < 2) begin : g_bad
      $error("irq_priority needs at least two sources");
    end
  endgenerate

  // lowest index wins; scan from the top so the last hit stands
  function automatic logic [W-1:0] first_set(input logic [N-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = W'(i);
      end
    end
    return r;
  endfunction

  assign bus.any = |bus.pend;
  assign bus.idx = first_set(bus.pend);
endmodule

// ==== rtl/reset_and_interrupt_sequencer.sv ====
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
module reset_and_interrupt_sequencer #(
  parameter int OSC_CYCLES = reset_seq_pkg::OSC_CYC, // stabilisation delay
  parameter int EXT_MIN = reset_seq_pkg::EXT_MIN_CYC // pin low cycles to count
) (
  input wire logic CLK, // reference clock, 20 MHz
  input wire logic ARST_N, // power-up reset, async
  input wire logic RST_PIN_I, // reset pin level
  output logic RST_PIN_O, // reset pin drive level
  output logic RST_PIN_OE, // reset pin pull-down enable
  input wire logic POWER_UP_PULSE, // power-on event, async
  input wire logic LOW_SUPPLY, // supply below rising trip, async
  input wire logic WDOG_OVF, // watchdog counter overflow
  input wire logic BAD_OPCODE, // opcode outside the set
  input wire logic STOP_EXEC, // stop instruction executed
  input wire logic STOP_ALLOWED, // stop-allowed config bit
  input wire logic FETCH_UNMAPPED, // opcode fetch, unmapped
  input wire logic DATA_UNMAPPED, // data fetch, unmapped
  input wire logic MONITOR_FORCE, // forced monitor entry
  input wire logic MONITOR_MODE, // monitor mode active
  input wire logic [15:0] ADDR, // register address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after RD
  output logic WDOG_CLEAR, // watchdog counter clear pulse
  output logic CPU_RESET, // core held in reset
  output logic CLOCKS_ON, // core and module clocks enabled
  output logic BUS_CLK_EN, // bus clock enable pulse
  output logic [15:0] RESET_VECTOR, // reset vector address
  input wire logic [reset_seq_pkg::IRQ_N-1:0] IRQ_PEND, // pending requests
  input wire logic INSTR_DONE, // instruction completed
  input wire logic SOFT_TRAP, // completed instruction is trap
  input wire logic MASK_LOAD, // mask written this cycle
  input wire logic MASK_VAL, // new mask value
  input wire logic VECTOR_TAKEN, // core fetched the vector
  output logic INT_ENTRY, // interrupt entry pulse
  output logic [15:0] INT_VECTOR, // vector address of entry
  output logic PUSH_PC_MINUS1, // stack counter minus one
  output logic INT_BUSY, // entry latched
  output logic I_MASK // global interrupt mask
);
  localparam int CW = 13;

  generate
    if (OSC_CYCLES < 1 || OSC_CYCLES > 8191 || EXT_MIN < 1 || EXT_MIN > 255) begin : g_bad
      $error("reset_and_interrupt_sequencer: count parameter out of range");
    end
  endgenerate

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    reset_seq_pkg::state_t st;
    logic [CW-1:0] cnt;
    logic [7:0] ext_cnt;
    logic from_int; // hold entered after our own pin drive
    logic [7:0] flags;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] div;
    logic div_en;
    logic [7:0] rdata;
    logic wdog_clr;
    logic mon;
    logic imask;
    logic busy;
    logic entry;
    logic pc_adj;
    logic [15:0] vec;
  } regs_t;

  regs_t q;
  regs_t d;
  arb_if arb ();

  irq_priority u_prio (
    .bus(arb.arb)
  );

  assign arb.pend = IRQ_PEND;

  // pin, power-up and supply come from outside: two flops each
  logic pin_low;
  logic por_ev;
  logic low_ev;
  logic rd_hit;
  logic [7:0] set_bits;
  logic [CW-1:0] osc_last;
  logic [15:0] irq_vec;

  assign pin_low = !q.s2[0];
  assign por_ev = q.s2[1];
  assign low_ev = q.s2[2];
  assign rd_hit = RD && (ADDR == reset_seq_pkg::CAUSE_ADDR);
  assign osc_last = CW'(OSC_CYCLES - 1);
  assign irq_vec = reset_seq_pkg::VEC_IRQ1 - {11'h000, arb.idx, 1'b0};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    set_bits = 8'h00;
    d.s1 = {LOW_SUPPLY, POWER_UP_PULSE, RST_PIN_I};
    d.s2 = q.s1;
    d.cnt = q.cnt + CW'(1);
    d.wdog_clr = 1'b0;
    d.entry = 1'b0;
    d.rdata = 8'h00;
    d.mon = MONITOR_MODE;
    d.div = q.div + 2'h1;
    d.div_en = (q.div == 2'(reset_seq_pkg::BUS_DIV - 2)) && (q.st == reset_seq_pkg::S_RUN);
    if (q.st != reset_seq_pkg::S_RUN) begin
      d.div = 2'h0;
    end
    case (q.st)
      reset_seq_pkg::S_RUN: begin
        d.cnt = '0;
        d.from_int = 1'b1;
        if (WDOG_OVF) begin
          set_bits[reset_seq_pkg::B_WDOG] = 1'b1;
        end
        if (BAD_OPCODE || (STOP_EXEC && !STOP_ALLOWED)) begin
          set_bits[reset_seq_pkg::B_OP] = 1'b1;
        end
        // opcode fetches only, data fetch ignored
        if (FETCH_UNMAPPED) begin
          set_bits[reset_seq_pkg::B_FETCH] = 1'b1;
        end
        if (MONITOR_FORCE) begin
          set_bits[reset_seq_pkg::B_MON] = 1'b1;
        end
        d.ext_cnt = pin_low ? q.ext_cnt + 8'h01 : 8'h00;
        if (set_bits != 8'h00) begin
          d.st = reset_seq_pkg::S_PIN_LOW;
          d.ext_cnt = 8'h00;
        end else if (pin_low && (q.ext_cnt == 8'(EXT_MIN - 1))) begin
          set_bits[reset_seq_pkg::B_PIN] = 1'b1;
          d.st = reset_seq_pkg::S_EXT;
          d.ext_cnt = 8'h00;
        end
      end
      reset_seq_pkg::S_EXT: begin
        // released by the outside party, then the normal hold
        d.cnt = '0;
        d.from_int = 1'b0;
        if (!pin_low) begin
          d.st = reset_seq_pkg::S_HOLD;
        end
      end
      reset_seq_pkg::S_LOW_WAIT: begin
        // pin low while supply below trip
        d.cnt = '0;
        if (!low_ev) begin
          d.st = reset_seq_pkg::S_OSC_WAIT;
        end
      end
      reset_seq_pkg::S_OSC_WAIT: begin
        if (q.cnt == osc_last) begin
          d.cnt = '0;
          d.st = reset_seq_pkg::S_PIN_LOW;
        end
      end
      reset_seq_pkg::S_PIN_LOW: begin
        d.from_int = 1'b1;
        if (q.cnt == CW'(reset_seq_pkg::PIN_LOW_CYC - 1)) begin
          d.cnt = '0;
          d.st = reset_seq_pkg::S_HOLD;
        end
      end
      reset_seq_pkg::S_HOLD: begin
        if (q.cnt == CW'(reset_seq_pkg::HOLD_CYC - 1)) begin
          d.cnt = '0;
          d.st = reset_seq_pkg::S_RUN;
          if (q.from_int && pin_low) begin
            set_bits[reset_seq_pkg::B_PIN] = 1'b1;
          end
        end
      end
      default: begin
        d.st = reset_seq_pkg::S_OSC_WAIT;
        d.cnt = '0;
      end
    endcase
    // supply and power events override any sequence in progress
    if (low_ev) begin
      set_bits[reset_seq_pkg::B_LVI] = 1'b1;
      d.st = reset_seq_pkg::S_LOW_WAIT;
      d.cnt = '0;
    end
    if (rd_hit) begin
      d.rdata = q.flags;
    end
    d.flags = (rd_hit ? 8'h00 : q.flags) | set_bits;
    if (por_ev) begin
      d.flags = reset_seq_pkg::CAUSE_POR_INIT;
      d.st = reset_seq_pkg::S_OSC_WAIT;
      d.cnt = '0;
    end
    // any write to the control location
    if (WR && (ADDR == reset_seq_pkg::WDOG_ADDR)) begin
      d.wdog_clr = 1'b1;
    end
    if (MASK_LOAD) begin
      d.imask = MASK_VAL;
    end
    if (VECTOR_TAKEN) begin
      d.busy = 1'b0;
    end
    if (INSTR_DONE && !q.busy && q.st == reset_seq_pkg::S_RUN) begin
      // trap ignores mask, stacks plain counter
      if (SOFT_TRAP) begin
        d.entry = 1'b1;
        d.vec = reset_seq_pkg::VEC_TRAP;
        d.pc_adj = 1'b0;
      end else if (!(MASK_LOAD ? MASK_VAL : q.imask) && arb.any) begin
        d.entry = 1'b1;
        d.vec = irq_vec;
        d.pc_adj = 1'b1;
      end
      if (d.entry) begin
        d.busy = 1'b1;
        d.imask = 1'b1;
      end
    end
    // reset aborts and drops any entry
    if (q.st != reset_seq_pkg::S_RUN) begin
      d.busy = 1'b0;
      d.imask = 1'b1;
      d.entry = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // power-up reset leaves the power-on sequence running
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '{st: reset_seq_pkg::S_OSC_WAIT, cnt: '0, ext_cnt: 8'h00, from_int: 1'b1,
             flags: reset_seq_pkg::CAUSE_POR_INIT, s1: 3'h1, s2: 3'h1, div: 2'h0,
             div_en: 1'b0, rdata: 8'h00, wdog_clr: 1'b0, mon: 1'b0, imask: 1'b1,
             busy: 1'b0, entry: 1'b0, pc_adj: 1'b0, vec: 16'h0000};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open drain: level is always low, only the enable moves
  assign RST_PIN_O = 1'b0;
  assign RST_PIN_OE = (q.st == reset_seq_pkg::S_LOW_WAIT) ||
                      (q.st == reset_seq_pkg::S_OSC_WAIT) ||
                      (q.st == reset_seq_pkg::S_PIN_LOW);
  assign CLOCKS_ON = (q.st != reset_seq_pkg::S_LOW_WAIT) &&
                     (q.st != reset_seq_pkg::S_OSC_WAIT);
  assign CPU_RESET = q.st != reset_seq_pkg::S_RUN;
  // monitor mode picks the alternate vector
  assign RESET_VECTOR = q.mon ? reset_seq_pkg::VEC_MONITOR : reset_seq_pkg::VEC_RESET;
  assign RDATA = q.rdata;
  assign WDOG_CLEAR = q.wdog_clr;
  assign BUS_CLK_EN = q.div_en;
  assign INT_ENTRY = q.entry;
  assign INT_VECTOR = q.vec;
  assign PUSH_PC_MINUS1 = q.pc_adj;
  assign INT_BUSY = q.busy;
  assign I_MASK = q.imask;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  logic unused_data;
  assign unused_data = DATA_UNMAPPED ^ (|WDATA);

  por_flags_a: assert property (por_ev |=> q.flags == reset_seq_pkg::CAUSE_POR_INIT)
    else $error("power-on flags wrong");
  pin_low_len_a: assert property (
    (q.st == reset_seq_pkg::S_PIN_LOW && q.cnt == '0 && !por_ev && !low_ev)
    |-> ##31 (RST_PIN_OE && !por_ev && !low_ev) ##1 !RST_PIN_OE && CPU_RESET)
    else $error("pin low length wrong");
  hold_len_a: assert property (
    (q.st == reset_seq_pkg::S_HOLD && q.cnt == CW'(31) && !por_ev && !low_ev)
    |=> !CPU_RESET)
    else $error("core release late");
  osc_wait_a: assert property (
    (q.st == reset_seq_pkg::S_OSC_WAIT) |-> !CLOCKS_ON && RST_PIN_OE && CPU_RESET)
    else $error("clocks on during stabilisation");
  read_clear_a: assert property (
    (rd_hit && set_bits == 8'h00 && !por_ev) |=> q.flags == 8'h00 && RDATA == $past(q.flags))
    else $error("read did not clear");
  flags_keep_a: assert property (
    (!rd_hit && !por_ev) |=> (q.flags & $past(q.flags)) == $past(q.flags))
    else $error("flag lost");
  data_fetch_a: assert property (
    (q.st == reset_seq_pkg::S_RUN && DATA_UNMAPPED && !WDOG_OVF && !BAD_OPCODE && !STOP_EXEC
     && !FETCH_UNMAPPED && !MONITOR_FORCE && !pin_low && !por_ev && !low_ev) |=> !CPU_RESET)
    else $error("data fetch caused reset");
  trap_entry_a: assert property (
    (INSTR_DONE && SOFT_TRAP && !q.busy && !CPU_RESET)
    |=> INT_ENTRY && INT_VECTOR == reset_seq_pkg::VEC_TRAP && !PUSH_PC_MINUS1)
    else $error("trap entry wrong");
  no_preempt_a: assert property (
    (INT_BUSY && !VECTOR_TAKEN && !CPU_RESET) |=> $stable(INT_VECTOR) && !INT_ENTRY)
    else $error("latched entry preempted");
  entry_mask_a: assert property (INT_ENTRY |-> I_MASK && INT_BUSY)
    else $error("mask not set on entry");
  bus_div_a: assert property (BUS_CLK_EN |=> !BUS_CLK_EN [*3])
    else $error("bus enable not one in four");

  internal_reset_c: cover property (q.st == reset_seq_pkg::S_PIN_LOW ##1
                                    q.st == reset_seq_pkg::S_HOLD);
  irq_entry_c: cover property (INT_ENTRY && PUSH_PC_MINUS1);
  late_pin_c: cover property (q.st == reset_seq_pkg::S_HOLD && q.from_int && pin_low
                              ##1 q.flags[reset_seq_pkg::B_PIN]);
endmodule

// ==== rtl/reset_seq_pkg.sv ====
// Notes on behaviour
// - any reset aborts, vector FFFE or FEFE
// - reset selects reference clock divided by four
// - long external pin low sets pin flag
// - internal reset: pin low 32, hold 32
// - power-on: clocks off 4096 cycles, pin low
// - after delay: pin free 32, core 64
// - power-on sets power and supply flags only
// - watchdog overflow resets; write FFFF clears counter
// - low supply: pin low, delay, supply flag
// - bad opcode or forbidden stop sets opcode flag
// - unmapped opcode fetch resets; data fetch not
// - cause register read-only, read clears all
// - cause flags accumulate until read
// - pin still low 32 after release: flag
// - forced monitor entry sets monitor flag
// - interrupts wait for instruction completion
// - entry stacks, sets mask, loads vector
// - unmasked: highest priority pending served first
// - latched interrupt cannot be preempted
// - return restores mask; pending served next
// - index-high register never stacked
// - soft trap unmaskable, pushes plain counter
// - mask blocks all but trap; 0 highest
package reset_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] CAUSE_ADDR = 16'hfe01;
  localparam logic [15:0] WDOG_ADDR = 16'hffff;
  localparam int B_POR = 7;
  localparam int B_PIN = 6;
  localparam int B_WDOG = 5;
  localparam int B_OP = 4;
  localparam int B_FETCH = 3;
  localparam int B_MON = 2;
  localparam int B_LVI = 1;
  localparam logic [7:0] CAUSE_POR_INIT = 8'h82;
  localparam int PIN_LOW_CYC = 32;
  localparam int HOLD_CYC = 32;
  localparam int OSC_CYC = 4096;
  localparam int EXT_MIN_CYC = 4;
  localparam int BUS_DIV = 4;
  localparam int IRQ_N = 16;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR = 16'hfefe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_IRQ1 = 16'hfffa;
  typedef enum logic [2:0] {
    S_RUN = 3'b000,
    S_LOW_WAIT = 3'b001,
    S_OSC_WAIT = 3'b010,
    S_PIN_LOW = 3'b011,
    S_HOLD = 3'b100,
    S_EXT = 3'b101
  } state_t;
endpackage

// ==== tb/far_side_model.sv ====
`timescale 1ns/100ps
// ****************
// far side: reset wire and core
// ****************
module far_side_model (
  input wire logic clk, // reference clock
  input wire logic pin_oe, // block pulls the pin
  input wire logic pin_o, // block drive level
  input wire logic ext_low, // outside device pulls the pin
  output logic pin_lvl, // resolved pin level
  input wire logic int_entry, // entry pulse from block
  input wire logic [3:0] lat, // cycles before vector fetch
  output logic vec_taken // core took the vector
);
  int cnt = -1;
  // outside party pulls low
  // open drain with pull-up: a released pin reads high, never stale
  assign pin_lvl = ((pin_oe && !pin_o) || ext_low) ? 1'b0 : 1'b1;
  // core fetches the vector lat+1 cycles after it sees entry, prompt or slow
  always @(posedge clk) begin
    vec_taken <= 1'b0;
    if (int_entry) begin
      cnt <= lat;
    end else if (cnt == 0) begin
      vec_taken <= 1'b1;
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== tb/tb_reset_and_interrupt_sequencer.sv ====
`timescale 1ns/100ps
module tb_reset_and_interrupt_sequencer;
  logic CLK = 0, ARST_N = 0, RST_PIN_I, RST_PIN_O, RST_PIN_OE, POWER_UP_PULSE = 0;
  logic LOW_SUPPLY = 0, WDOG_OVF = 0, BAD_OPCODE = 0, STOP_EXEC = 0, STOP_ALLOWED = 1;
  logic FETCH_UNMAPPED = 0, DATA_UNMAPPED = 0, MONITOR_FORCE = 0, MONITOR_MODE = 0;
  logic [15:0] ADDR = '0, RESET_VECTOR, INT_VECTOR, IRQ_PEND = '0;
  logic [7:0] WDATA = '0, RDATA, d;
  logic WR = 0, RD = 0, WDOG_CLEAR, CPU_RESET, CLOCKS_ON, BUS_CLK_EN, INSTR_DONE = 0;
  logic SOFT_TRAP = 0, MASK_LOAD = 0, MASK_VAL = 0, VECTOR_TAKEN, INT_ENTRY;
  logic PUSH_PC_MINUS1, INT_BUSY, I_MASK, ext_low = 0;
  logic [3:0] lat = 4'h0;
  int err_count = 0, check_count = 0, cyc = 0, o, t;
  localparam int OSC = 80;
  // ****************
  // design and far side
  // ****************
  reset_and_interrupt_sequencer #(.OSC_CYCLES(OSC), .EXT_MIN(2)) dut_u (.*);
  far_side_model far_u (.clk(CLK), .pin_oe(RST_PIN_OE), .pin_o(RST_PIN_O),
    .ext_low(ext_low), .pin_lvl(RST_PIN_I), .int_entry(INT_ENTRY), .lat(lat),
    .vec_taken(VECTOR_TAKEN));
  always #25 CLK = ~CLK;
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the whole run
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic rd_reg(input logic [15:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  // waits for a reset to start, then counts pin-low and held cycles
  task automatic measure();
    int k;
    k = 0;
    o = 0;
    t = 0;
    while (CPU_RESET !== 1'b1 && k < 8) begin
      @(posedge CLK);
      #1 k++;
    end
    while (CPU_RESET === 1'b1 && t < 400) begin
      if (RST_PIN_OE === 1'b1) o++;
      t++;
      @(posedge CLK);
      #1;
    end
  endtask
  task automatic fire(input int i);
    @(posedge CLK);
    case (i)
      0: WDOG_OVF <= 1'b1;
      1: BAD_OPCODE <= 1'b1;
      3: FETCH_UNMAPPED <= 1'b1;
      4: MONITOR_FORCE <= 1'b1;
      5: DATA_UNMAPPED <= 1'b1;
      default: STOP_EXEC <= 1'b1;
    endcase
    STOP_ALLOWED <= (i == 6);
    @(posedge CLK);
    {WDOG_OVF, BAD_OPCODE, STOP_EXEC, FETCH_UNMAPPED, MONITOR_FORCE, DATA_UNMAPPED} <= '0;
    #1;
  endtask
  task automatic idone(input logic [15:0] p, input logic tr, input logic ml);
    @(posedge CLK);
    INSTR_DONE <= 1'b1;
    IRQ_PEND <= p;
    SOFT_TRAP <= tr;
    MASK_LOAD <= ml;
    @(posedge CLK);
    {INSTR_DONE, SOFT_TRAP, MASK_LOAD} <= '0;
    IRQ_PEND <= '0;
    #1;
  endtask
  task automatic wait_free();
    int k;
    k = 0;
    while (INT_BUSY !== 1'b0 && k < 20) begin
      @(posedge CLK);
      #1 k++;
    end
    chk(INT_BUSY, 0, "busy stuck");
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_causes();
    logic [7:0] exp [7] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      fire(i);
      measure();
      chk(t, exp[i] ? 64 : 0, "held cycles");
      chk(o, exp[i] ? 32 : 0, "pin low cycles");
      rd_reg(reset_seq_pkg::CAUSE_ADDR);
      chk(d, exp[i], "cause flags");
    end
    fire(0);
    measure();
    fire(3);
    measure();
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h28, "accumulated");
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h00, "read clears");
    @(posedge CLK);
    RD <= 1'b1;
    WDOG_OVF <= 1'b1;
    @(posedge CLK);
    {RD, WDOG_OVF} <= '0;
    #1;
    measure();
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h20, "set beats clear");
    fire(1);
    measure();
    @(posedge CLK);
    POWER_UP_PULSE <= 1'b1;
    repeat (3) @(posedge CLK);
    POWER_UP_PULSE <= 1'b0;
    #1;
    measure();
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h82, "power-on flags");
  endtask
  task automatic t_pins();
    @(posedge CLK);
    ext_low <= 1'b1;
    fire(0);
    measure();
    @(posedge CLK);
    ext_low <= 1'b0;
    #1;
    measure();
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h60, "pin still low");
    @(posedge CLK);
    ext_low <= 1'b1;
    repeat (6) @(posedge CLK);
    ext_low <= 1'b0;
    #1;
    measure();
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h40, "external pin");
    @(posedge CLK);
    LOW_SUPPLY <= 1'b1;
    repeat (20) @(posedge CLK);
    #1 chk({RST_PIN_OE, CLOCKS_ON, BUS_CLK_EN}, 3'b100, "supply low");
    @(posedge CLK);
    LOW_SUPPLY <= 1'b0;
    #1;
    measure();
    chk(t inside {[OSC + 60 : OSC + 70]}, 1, "supply release");
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h02, "supply flag");
  endtask
  task automatic t_regs();
    wr_reg(reset_seq_pkg::WDOG_ADDR, 8'h5a);
    chk(WDOG_CLEAR, 1, "watchdog clear");
    wr_reg(reset_seq_pkg::CAUSE_ADDR, 8'hff);
    rd_reg(reset_seq_pkg::CAUSE_ADDR);
    chk(d, 8'h82, "read only");
    rd_reg(16'h1234);
    chk(d, 8'h00, "unmapped read");
    o = 0;
    repeat (16) begin
      @(posedge CLK);
      #1 o += BUS_CLK_EN;
    end
    chk(o, 4, "bus clock div");
    @(posedge CLK);
    MONITOR_MODE <= 1'b1;
    repeat (2) @(posedge CLK);
    #1 chk(RESET_VECTOR, 16'hfefe, "monitor vector");
    @(posedge CLK);
    MONITOR_MODE <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk(RESET_VECTOR, 16'hfffe, "reset vector");
  endtask
  task automatic t_irq();
    chk(I_MASK, 1, "mask after reset");
    idone(16'h0006, 0, 0);
    chk(INT_ENTRY, 0, "masked");
    idone(16'h0000, 1, 0);
    chk({INT_ENTRY, PUSH_PC_MINUS1}, 2'b10, "trap entry");
    chk(INT_VECTOR, 16'hfffc, "trap vector");
    wait_free();
    idone(16'h0000, 0, 1);
    @(posedge CLK);
    IRQ_PEND <= 16'h8000;
    repeat (5) @(posedge CLK);
    #1 chk(INT_ENTRY, 0, "no done no entry");
    lat <= 4'h8;
    idone(16'h0006, 0, 1);
    chk({INT_ENTRY, I_MASK, PUSH_PC_MINUS1}, 3'b111, "entry");
    chk(INT_VECTOR, 16'hfff8, "highest first");
    idone(16'h0001, 0, 1);
    chk({INT_ENTRY, INT_VECTOR}, 17'h0fff8, "no preempt");
    wait_free();
    lat <= 4'h0;
    for (int b = 0; b < 16; b++) begin
      idone(16'h0001 << b, 0, 1);
      chk(INT_VECTOR, 16'hfffa - 16'(2 * b), "vector");
      wait_free();
    end
    // a return that restores a set mask must hold off a pending request
    @(posedge CLK);
    MASK_VAL <= 1'b1;
    idone(16'h0004, 0, 1);
    chk({INT_ENTRY, I_MASK}, 2'b01, "restored mask holds off");
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    ARST_N <= 1'b1;
    #1 chk({RST_PIN_OE, CLOCKS_ON, CPU_RESET}, 3'b101, "power-up");
    measure();
    chk(t inside {[OSC + 62 : OSC + 66]}, 1, "core release");
    chk(o inside {[OSC + 30 : OSC + 34]}, 1, "pin release");
    t_regs();
    t_causes();
    t_pins();
    t_irq();
    conclude();
  end
endmodule
